// *** verilog/tws_pkg.sv ***
// Purpose: constants shared by the two-wire slave state machine
// Assumes: 8-bit registers reached over a plain strobe port
// Notes: status codes assume the prescaler field masked to zero
package tws_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int ADDR_W = 2;
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_STAT = 2'h1;
    localparam logic [1:0] REG_DATA = 2'h2;
    localparam logic [1:0] REG_OWN = 2'h3;
    // ----------------------------------------
    // control_reg fields
    // ----------------------------------------
    localparam int CB_FLAG = 7;
    localparam int CB_ACK = 6;
    localparam int CB_BEGIN = 5;
    localparam int CB_HALT = 4;
    localparam int CB_WCOL = 3;
    localparam int CB_EN = 2;
    localparam int CB_IRQ = 0;
    localparam logic [7:0] CTRL_WMASK = 8'h75;
    // ----------------------------------------
    // values after reset
    // ----------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] OWN_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'hff;
    localparam logic [1:0] PRESC_RST = 2'h0;
    // ----------------------------------------
    // status codes
    // ----------------------------------------
    localparam logic [7:0] ST_SR_OWN = 8'h60;
    localparam logic [7:0] ST_SR_OWN_AL = 8'h68;
    localparam logic [7:0] ST_SR_GC = 8'h70;
    localparam logic [7:0] ST_SR_GC_AL = 8'h78;
    localparam logic [7:0] ST_SR_DATA_ACK = 8'h80;
    localparam logic [7:0] ST_SR_DATA_NACK = 8'h88;
    localparam logic [7:0] ST_GC_DATA_ACK = 8'h90;
    localparam logic [7:0] ST_GC_DATA_NACK = 8'h98;
    localparam logic [7:0] ST_STOP_RS = 8'ha0;
    localparam logic [7:0] ST_ST_OWN = 8'ha8;
    localparam logic [7:0] ST_ST_OWN_AL = 8'hb0;
    localparam logic [7:0] ST_ST_DATA_ACK = 8'hb8;
    localparam logic [7:0] ST_ST_DATA_NACK = 8'hc0;
    localparam logic [7:0] ST_ST_LAST_ACK = 8'hc8;
    localparam logic [7:0] ST_NONE = 8'hf8;
    // ----------------------------------------
    // bus framing
    // ----------------------------------------
    localparam logic [6:0] GC_ADDR = 7'h00;
    localparam logic DIR_READ = 1'b1;
    localparam logic [2:0] BIT_LAST = 3'h7;
endpackage : tws_pkg

// *** verilog/tws_pin_sync.sv ***
// Purpose: two-flop synchronisers and edge detect for the bus pins
// Assumes: pins are asynchronous to clk
// Notes: edges come from stages two and three only
`timescale 1ns/1ps
module tws_pin_sync #(
    parameter int W = 2
) (
    // clock, reset and enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // pins and results
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    // ----------------------------------------
    // one chain per pin
    // ----------------------------------------
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_pin
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    s1_q[i] <= 1'b1;
                    s2_q[i] <= 1'b1;
                    s3_q[i] <= 1'b1;
                end else if (ce) begin
                    s1_q[i] <= pin_in[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                end
            end
            assign level[i] = s2_q[i];
            assign rise[i] = s2_q[i] & ~s3_q[i];
            assign fall[i] = ~s2_q[i] & s3_q[i];
        end
    endgenerate
endmodule : tws_pin_sync

// *** verilog/tws_slave.sv ***
// Purpose: slave receiver/transmitter state machine of the two-wire unit
// Assumes: bus pins open drain; scl and sda sampled by clk
// Notes: master modes, bus error recovery and baud prescaler not present
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
module tws_slave
    import tws_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata_q,
    // bus pins
    input wire logic scl_in,
    output logic scl_out_q,
    output logic scl_oe_q,
    input wire logic sda_in,
    output logic sda_out_q,
    output logic sda_oe_q,
    // system side
    input wire logic sleep_deep,
    input wire logic arb_lost,
    output logic wake_q,
    output logic start_cond_q
);
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_AACK, S_RX, S_RACK, S_TX, S_TACK, S_HOLD
    } tws_state_e;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [1:0] lvl;
    logic [1:0] rise;
    logic [1:0] fall;
    tws_pin_sync #(.W(2)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .pin_in({sda_in, scl_in}),
        .level(lvl),
        .rise(rise),
        .fall(fall)
    );
    logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
    assign scl_s = lvl[0];
    assign sda_s = lvl[1];
    assign scl_rise = rise[0];
    assign scl_fall = fall[0];
    assign start_det = fall[1] & scl_s;
    assign stop_det = rise[1] & scl_s;

    // ----------------------------------------
    // state
    // ----------------------------------------
    tws_state_e st_q, st_d;
    logic [2:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic drv_q, drv_d, gc_q, gc_d, tx_q, tx_d, last_q, last_d;
    logic exit_q, exit_d, ackp_q, ackp_d, busy_q, busy_d;
    logic [7:0] ctrl_q, ctrl_d, own_q, own_d, data_q, data_d, stat_q, stat_d, rdata_d;
    logic [1:0] presc_q, presc_d;
    logic flag_q, flag_d, wcol_q, wcol_d, pend_q, pend_d, start_d, wake_d;
    logic hw_set, rx_load, wake_set;
    logic [7:0] hw_code;

    logic en, ack_en, sw_clr, addressed, own_hit, gc_hit, hit;
    assign en = ctrl_q[CB_EN];
    assign ack_en = ctrl_q[CB_ACK];
    assign sw_clr = wr && addr == REG_CTRL && wdata[CB_FLAG];
    assign addressed = st_q inside {S_RX, S_RACK, S_TX, S_TACK} || (st_q == S_HOLD && !exit_q);
    assign own_hit = sh_q[6:0] == own_q[7:1];
    assign gc_hit = sh_q[6:0] == GC_ADDR && own_q[0] && sda_s != DIR_READ;
    assign hit = ack_en && (own_hit || gc_hit);

    // ----------------------------------------
    // bus state machine
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        drv_d = drv_q;
        gc_d = gc_q;
        tx_d = tx_q;
        last_d = last_q;
        exit_d = exit_q;
        ackp_d = ackp_q;
        busy_d = busy_q;
        hw_set = 1'b0;
        hw_code = ST_NONE;
        rx_load = 1'b0;
        wake_set = 1'b0;
        if (start_det) begin
            busy_d = 1'b1;
        end
        if (stop_det) begin
            busy_d = 1'b0;
        end
        if (!en) begin
            st_d = S_IDLE;
            drv_d = 1'b0;
        end else if (start_det || stop_det) begin
            if (addressed) begin
                hw_set = 1'b1;
                hw_code = ST_STOP_RS;
            end
            st_d = start_det ? S_ADDR : S_IDLE;
            cnt_d = 3'h0;
            drv_d = 1'b0;
        end else begin
            case (st_q)
                S_IDLE: begin
                    drv_d = 1'b0;
                end
                S_ADDR: if (scl_rise) begin
                    sh_d = {sh_q[6:0], sda_s};
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == BIT_LAST) begin
                        cnt_d = 3'h0;
                        st_d = hit ? S_AACK : S_IDLE;
                        gc_d = gc_hit && !own_hit;
                        tx_d = sda_s == DIR_READ;
                        last_d = 1'b0;
                        exit_d = 1'b0;
                    end
                end
                S_AACK: if (scl_fall) begin
                    if (cnt_q == 3'h0) begin
                        drv_d = 1'b1;
                        cnt_d = 3'h1;
                    end else begin
                        drv_d = 1'b0;
                        cnt_d = 3'h0;
                        hw_set = 1'b1;
                        wake_set = sleep_deep;
                        st_d = S_HOLD;
                        if (tx_q) begin
                            hw_code = arb_lost ? ST_ST_OWN_AL : ST_ST_OWN;
                        end else if (gc_q) begin
                            hw_code = arb_lost ? ST_SR_GC_AL : ST_SR_GC;
                        end else begin
                            hw_code = arb_lost ? ST_SR_OWN_AL : ST_SR_OWN;
                        end
                    end
                end
                S_RX: if (scl_rise) begin
                    sh_d = {sh_q[6:0], sda_s};
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == BIT_LAST) begin
                        cnt_d = 3'h0;
                        st_d = S_RACK;
                    end
                end
                S_RACK: if (scl_fall) begin
                    if (cnt_q == 3'h0) begin
                        drv_d = ackp_q;
                        cnt_d = 3'h1;
                    end else begin
                        drv_d = 1'b0;
                        cnt_d = 3'h0;
                        rx_load = 1'b1;
                        hw_set = 1'b1;
                        exit_d = !ackp_q;
                        st_d = S_HOLD;
                        if (gc_q) begin
                            hw_code = ackp_q ? ST_GC_DATA_ACK : ST_GC_DATA_NACK;
                        end else begin
                            hw_code = ackp_q ? ST_SR_DATA_ACK : ST_SR_DATA_NACK;
                        end
                    end
                end
                S_TX: if (scl_fall) begin
                    if (cnt_q == BIT_LAST) begin
                        drv_d = 1'b0;
                        cnt_d = 3'h0;
                        st_d = S_TACK;
                    end else begin
                        sh_d = {sh_q[6:0], 1'b1};
                        drv_d = !sh_q[6];
                        cnt_d = cnt_q + 3'h1;
                    end
                end
                S_TACK: begin
                    if (scl_rise) begin
                        ackp_d = !sda_s;
                    end
                    if (scl_fall) begin
                        hw_set = 1'b1;
                        exit_d = !ackp_q || last_q;
                        st_d = S_HOLD;
                        if (!ackp_q) begin
                            hw_code = ST_ST_DATA_NACK;
                        end else begin
                            hw_code = last_q ? ST_ST_LAST_ACK : ST_ST_DATA_ACK;
                        end
                    end
                end
                S_HOLD: if (sw_clr) begin
                    cnt_d = 3'h0;
                    if (exit_q) begin
                        st_d = S_IDLE;
                    end else if (tx_q) begin
                        st_d = S_TX;
                        sh_d = data_q;
                        drv_d = !data_q[7];
                        last_d = !wdata[CB_ACK];
                    end else begin
                        st_d = S_RX;
                        ackp_d = wdata[CB_ACK];
                    end
                end
                default: st_d = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= S_IDLE;
            cnt_q <= 3'h0;
            sh_q <= 8'h00;
            drv_q <= 1'b0;
            gc_q <= 1'b0;
            tx_q <= 1'b0;
            last_q <= 1'b0;
            exit_q <= 1'b0;
            ackp_q <= 1'b0;
            busy_q <= 1'b0;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_out_q <= 1'b0;
            scl_out_q <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            drv_q <= drv_d;
            gc_q <= gc_d;
            tx_q <= tx_d;
            last_q <= last_d;
            exit_q <= exit_d;
            ackp_q <= ackp_d;
            busy_q <= busy_d;
            sda_oe_q <= drv_d;
            scl_oe_q <= st_d == S_HOLD;
            sda_out_q <= 1'b0;
            scl_out_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        own_d = own_q;
        data_d = data_q;
        presc_d = presc_q;
        stat_d = stat_q;
        flag_d = flag_q;
        wcol_d = wcol_q;
        pend_d = pend_q;
        start_d = 1'b0;
        wake_d = wake_set;
        rdata_d = 8'h00;
        if (wr) begin
            case (addr)
                REG_CTRL: begin
                    ctrl_d = wdata & CTRL_WMASK;
                    if (wdata[CB_FLAG]) begin
                        flag_d = 1'b0;
                        // a stop or restart code is an exit as well, though it does not stretch
                        if (wdata[CB_BEGIN] && ((st_q == S_HOLD && exit_q) || (flag_q && stat_q == ST_STOP_RS))) begin
                            pend_d = 1'b1;
                        end
                    end
                end
                REG_STAT: presc_d = wdata[1:0];
                REG_DATA: begin
                    if (flag_q) begin
                        data_d = wdata;
                    end else begin
                        wcol_d = 1'b1;
                    end
                end
                REG_OWN: own_d = wdata;
                default: ;
            endcase
        end
        // wake on the address byte leaves data untouched
        if (rx_load) begin
            data_d = sh_q;
        end
        if (hw_set) begin
            flag_d = 1'b1;
            stat_d = hw_code;
        end
        if (pend_q && !busy_q && !flag_q) begin
            start_d = 1'b1;
            pend_d = 1'b0;
        end
        if (rd) begin
            case (addr)
                REG_CTRL: rdata_d = {flag_q, ctrl_q[6:4], wcol_q, ctrl_q[2:0]};
                REG_STAT: rdata_d = {flag_q ? stat_q[7:3] : ST_NONE[7:3], 1'b0, presc_q};
                REG_DATA: rdata_d = data_q;
                REG_OWN: rdata_d = own_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= CTRL_RST;
            own_q <= OWN_RST;
            data_q <= DATA_RST;
            presc_q <= PRESC_RST;
            stat_q <= ST_NONE;
            flag_q <= 1'b0;
            wcol_q <= 1'b0;
            pend_q <= 1'b0;
            start_cond_q <= 1'b0;
            wake_q <= 1'b0;
            rdata_q <= 8'h00;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            own_q <= own_d;
            data_q <= data_d;
            presc_q <= presc_d;
            stat_q <= stat_d;
            flag_q <= flag_d;
            wcol_q <= wcol_d;
            pend_q <= pend_d;
            start_cond_q <= start_d;
            wake_q <= wake_d;
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_addr_end;
        ce && en && !start_det && !stop_det && st_q == S_ADDR && scl_rise && cnt_q == BIT_LAST;
    endsequence
    sequence s_ack_end(tws_state_e s);
        ce && en && !start_det && !stop_det && st_q == s && scl_fall && cnt_q == 3'h1;
    endsequence

    a_stat_idle: assert property (@(posedge clk) disable iff (!nrst)
        ce && rd && addr == REG_STAT && !flag_q |=> rdata_q[7:3] == ST_NONE[7:3]) else $error("idle status wrong");
    a_hold_scl: assert property (@(posedge clk) disable iff (!nrst)
        st_q == S_HOLD |-> scl_oe_q && flag_q) else $error("scl not held");
    a_hold_until: assert property (@(posedge clk) disable iff (!nrst)
        ce && st_q == S_HOLD && !sw_clr && en && !start_det && !stop_det |=> st_q == S_HOLD)
        else $error("hold left early");
    a_gc_off: assert property (@(posedge clk) disable iff (!nrst)
        s_addr_end and (sh_q[6:0] == GC_ADDR && !own_q[0] && own_q[7:1] != GC_ADDR) |=> st_q == S_IDLE)
        else $error("general call answered");
    a_ack_iso: assert property (@(posedge clk) disable iff (!nrst)
        s_addr_end and !ack_en |=> st_q == S_IDLE ##1 !sda_oe_q) else $error("address acked while isolated");
    a_dir_tx: assert property (@(posedge clk) disable iff (!nrst)
        s_addr_end and hit && sda_s |=> st_q == S_AACK && tx_q) else $error("direction decode wrong");
    a_gc_data: assert property (@(posedge clk) disable iff (!nrst)
        s_ack_end(S_RACK) and gc_q && ackp_q |=> flag_q && stat_q == ST_GC_DATA_ACK) else $error("gc data code");
    a_last_ack: assert property (@(posedge clk) disable iff (!nrst)
        ce && en && !start_det && !stop_det && st_q == S_TACK && scl_fall && ackp_q && last_q
        |=> stat_q == ST_ST_LAST_ACK ##0 exit_q) else $error("last byte code");
    a_stop_addr: assert property (@(posedge clk) disable iff (!nrst)
        ce && en && stop_det && addressed |=> flag_q && stat_q == ST_STOP_RS && st_q == S_IDLE)
        else $error("stop while addressed");
    a_wake_addr: assert property (@(posedge clk) disable iff (!nrst)
        s_ack_end(S_AACK) and sleep_deep |=> wake_q ##1 !wake_q) else $error("no wake pulse");
endmodule : tws_slave

// *** dv/tws_bus_master.sv ***
// Purpose: behavioural master on the two-wire bus
// Assumes: open-drain lines pulled up; bench resolves them
// Notes: scl period 125 ns, stands still between frames
`timescale 1ns/1ps
module tws_bus_master (
    // resolved lines
    input wire logic scl,
    input wire logic sda,
    // releases, 1 = let go
    output logic scl_rel,
    output logic sda_rel
);
    initial begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
    end
    // let scl go, ride out a stretch (bounded), then hold high
    task automatic rise();
        scl_rel = 1'b1;
        for (int n = 0; n < 40000 && scl !== 1'b1; n++) #10;
        #62.5;
    endtask : rise
    task automatic start();
        sda_rel = 1'b1;
        #31.25;
        rise();
        sda_rel = 1'b0;
        #62.5;
        scl_rel = 1'b0;
        #31.25;
    endtask : start
    task automatic stop();
        sda_rel = 1'b0;
        #31.25;
        rise();
        sda_rel = 1'b1;
        #62.5;
    endtask : stop
    // sda set mid-low, sampled at the end of the high phase
    task automatic bit_x(input logic b, output logic r);
        sda_rel = b;
        #31.25;
        rise();
        r = sda;
        scl_rel = 1'b0;
        #31.25;
    endtask : bit_x
    // msb first, then the ack bit
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
        for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
        bit_x(ack_in, ack_out);
    endtask : xfer
endmodule : tws_bus_master

// *** dv/test_tws_slave.sv ***
// Purpose: self-checking bench for the two-wire slave
// Assumes: seed 44; bus master model drives scl and sda
// Notes: ce dropped once at the end to show a frozen write
`timescale 1ns/1ps
module test_tws_slave import tws_pkg::*; ;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sleep_deep = 1'b0;
    logic arb_lost = 1'b0;
    logic [7:0] rdata_q;
    logic scl_out_q, scl_oe_q, sda_out_q, sda_oe_q, wake_q, start_cond_q, m_scl, m_sda;
    int error_cnt = 0;
    int comparisons = 0;
    int wake_cnt = 0;
    int start_cnt = 0;
    wire scl = m_scl & (~scl_oe_q | scl_out_q);
    wire sda = m_sda & (~sda_oe_q | sda_out_q);
    tws_slave DUT (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_q(rdata_q), .scl_in(scl), .scl_out_q(scl_out_q), .scl_oe_q(scl_oe_q), .sda_in(sda),
        .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .sleep_deep(sleep_deep), .arb_lost(arb_lost),
        .wake_q(wake_q), .start_cond_q(start_cond_q));
    tws_bus_master BM (.scl(scl), .sda(sda), .scl_rel(m_scl), .sda_rel(m_sda));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        wake_cnt <= wake_cnt + int'(wake_q === 1'b1);
        start_cnt <= start_cnt + int'(start_cond_q === 1'b1);
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata_q;
    endtask : rd_reg
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // poll until the flag shows; prescaler masked before compare
    task automatic wait_code(input logic [7:0] exp);
        logic [7:0] s;
        s = ST_NONE;
        for (int n = 0; n < 300 && s === ST_NONE; n++) rd_reg(REG_STAT, s);
        chk(s & 8'hf8, exp);
    endtask : wait_code
    // 0 = acked; assumes the unit enabled
    function automatic logic addr_ack(input logic ack_en, input logic gce, input logic is_gc);
        return !(ack_en && (!is_gc || gce));
    endfunction : addr_ack
    task automatic report_and_stop();
        if (error_cnt == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        logic [7:0] v, d, own, rx;
        logic [7:0] rv [4];
        logic a;
        int k;
        void'($urandom(44));
        rv = '{CTRL_RST, ST_NONE | 8'(PRESC_RST), DATA_RST, OWN_RST};
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd_reg(2'(i), v);
            chk(v, rv[i]);
        end
        own = {7'($urandom_range(1, 127)), 1'b0};
        // every mix of ack enable, general call enable, own or general call
        for (int i = 0; i < 8; i++) begin
            a = addr_ack(i[0], i[1], i[2]);
            @(posedge clk);
            sleep_deep <= i[2];
            wr_reg(REG_OWN, own | 8'(i[1]));
            wr_reg(REG_CTRL, {1'b0, i[0], 6'h04});
            k = wake_cnt;
            BM.start();
            BM.xfer(i[2] ? 8'h00 : own, 1'b1, rx, v[0]);
            chk(8'(v[0]), 8'(a));
            // the wake pulse trails the ack fall by a few clocks
            repeat (6) @(posedge clk);
            chk(8'(wake_cnt - k), 8'(i[2] & !a));
            if (a == 1'b0) begin
                wait_code(i[2] ? ST_SR_GC : ST_SR_OWN);
                chk(8'(scl_oe_q), 8'h01);
                wr_reg(REG_CTRL, 8'hc4);
                BM.stop();
                wait_code(ST_STOP_RS);
                k = start_cnt;
                wr_reg(REG_CTRL, i[1] ? 8'he4 : 8'hc4);
                repeat (4) @(posedge clk);
                chk(8'(start_cnt - k), 8'(i[1]));
            end else begin
                BM.stop();
            end
        end
        sleep_deep <= 1'b0;
        // general call data, acked then refused
        BM.start();
        BM.xfer(8'h00, 1'b1, rx, a);
        wait_code(ST_SR_GC);
        for (int i = 0; i < 2; i++) begin
            d = 8'($urandom);
            wr_reg(REG_CTRL, i ? 8'h84 : 8'hc4);
            BM.xfer(d, 1'b1, rx, a);
            chk(8'(a), 8'(i));
            wait_code(i ? ST_GC_DATA_NACK : ST_GC_DATA_ACK);
            rd_reg(REG_DATA, v);
            chk(v, d);
        end
        wr_reg(REG_CTRL, 8'hc4);
        BM.stop();
        repeat (20) @(posedge clk);
        rd_reg(REG_STAT, v);
        chk(v, ST_NONE);
        // transmitter: plain and after lost arbitration
        for (int j = 0; j < 2; j++) begin
            @(posedge clk);
            arb_lost <= j[0];
            k = start_cnt;
            BM.start();
            BM.xfer(own | 8'h01, 1'b1, rx, a);
            wait_code(j ? ST_ST_OWN_AL : ST_ST_OWN);
            for (int i = 0; i < 2; i++) begin
                d = 8'($urandom);
                wr_reg(REG_DATA, d);
                wr_reg(REG_CTRL, i ? 8'h84 : 8'hc4);
                BM.xfer(8'hff, (i == 1) && (j == 1), rx, a);
                chk(rx, d);
                if (i == 0) wait_code(ST_ST_DATA_ACK);
            end
            wait_code(j ? ST_ST_DATA_NACK : ST_ST_LAST_ACK);
            wr_reg(REG_CTRL, j ? 8'he4 : 8'hc4);
            if (j == 0) BM.xfer(8'hff, 1'b1, rx, a);
            chk(8'(start_cnt - k), 8'h00);
            BM.stop();
            repeat (40) @(posedge clk);
            chk(8'(start_cnt - k), 8'(j));
            if (j == 0) chk(rx, 8'hff);
        end
        arb_lost <= 1'b0;
        // a write made while the clock enable is low must not land
        ce <= 1'b0;
        wr_reg(REG_OWN, 8'h5a);
        ce <= 1'b1;
        rd_reg(REG_OWN, v);
        chk(v, own | 8'h01);
        report_and_stop();
    end
    // a hang costs one mismatch
    initial begin
        #500us;
        error_cnt++;
        report_and_stop();
    end
endmodule : test_tws_slave
